// *** design/ufcf_framer.sv ***
// Upstream FEC codeword framer with APB registers
// What this block does
// - With FEC on, each burst runs in exactly one of fixed-length or shortened-last codeword mode.
// - No codeword in either mode carries fewer than 16 information bytes.
// - Contention and non-contention grants are framed by the very same rules.
// - In fixed mode the codeword holding the last data byte is zero-padded to the full size.
// - In fixed mode all-zero full codewords follow while a whole one with parity and guard still fits.
// - In shortened mode data including the header go out in full codewords until data run out or a remainder is left.
// - A shortened last codeword holds at least 16 bytes, and the requester sizes its grant with that in mind.
// - In shortened mode zero-fill runs to the end of the allocation, allowing for parity and guard.
// - In shortened mode all-zero full codewords follow while they fit, then one shortened zero codeword fills the rest.
// - If fewer than 16 bytes of room remain the final shortened codeword is left out.
// - With FEC off the data pass through unframed; with it on each block goes to the encoder, the last maybe short.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ufcf_framer
   import ufcf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        S_VALID,
   output logic             S_READY,
   input  wire logic [7:0]  S_DATA,
   output logic             O_VALID,
   input  wire logic        O_READY,
   output logic      [7:0]  O_DATA,
   output logic             O_SOC,
   output logic             O_EOC,
   output logic      [7:0]  O_CWLEN,
   output logic             O_BURST_DONE
);

   ufcf_cfg_t   cfg_r;
   ufcf_state_t state_r;
   ufcf_beat_t  beat_r;
   logic        o_valid_r;
   logic        start_r;
   logic        done_r;
   logic        trunc_r;
   logic        burst_done_r;
   logic [15:0] cw_count_r;
   logic [15:0] data_left_r;
   logic [15:0] cap_r;
   logic [7:0]  cw_left_r;
   logic [7:0]  cw_len_r;
   logic        first_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic        in_ready;
   logic        f_valid;
   logic [7:0]  f_data;
   logic        f_pop;
   logic        out_free;
   logic        wr_en;
   logic        mapped;
   logic [15:0] avail;
   logic [15:0] head_len;
   logic        done_set;
   logic        trunc_set;
   logic        s_ready_r;

   // Input FIFO, stalls the burst source when full
   ufcf_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (MCLK),
      .rst       (RST),
      .in_valid  (S_VALID && s_ready_r),
      .in_ready  (in_ready),
      .in_data   (S_DATA),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // S_READY follows FIFO room through a flop and drops for a cycle after each accepted byte; only offered bytes enter the FIFO
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         s_ready_r <= 1'b0;
      else
         s_ready_r <= in_ready && !(S_VALID && s_ready_r);
   end
   assign S_READY = s_ready_r;

   // APB decode
   assign mapped = (PADDR <= OFS_COUNT) && (PADDR[1:0] == 2'b00);
   assign wr_en  = PSEL && PENABLE && pready_r && PWRITE && mapped;

   // APB answer one cycle after setup, zero wait in access
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r  <= PSEL && !PENABLE;
         pslverr_r <= PSEL && !PENABLE && !mapped;
         prdata_r  <= 32'h0000_0000;
         if (PSEL && !PENABLE && !PWRITE)
         begin
            unique case (PADDR)
               OFS_CTRL:   prdata_r <= {30'h0000_0000, cfg_r.short_mode, cfg_r.fec_en};
               OFS_CWSIZE: prdata_r <= {24'h00_0000, cfg_r.cw_size};
               OFS_PARITY: prdata_r <= {24'h00_0000, cfg_r.parity};
               OFS_GUARD:  prdata_r <= {16'h0000, cfg_r.guard};
               OFS_GRANT:  prdata_r <= {16'h0000, cfg_r.grant};
               OFS_LEN:    prdata_r <= {16'h0000, cfg_r.len};
               OFS_STATUS: prdata_r <= {29'h0000_0000, trunc_r, done_r, (state_r != ST_IDLE)};
               OFS_COUNT:  prdata_r <= {16'h0000, cw_count_r};
               default:    prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign PREADY  = pready_r;
   assign PSLVERR = pslverr_r;
   assign PRDATA  = prdata_r;

   // Configuration registers, frozen while a burst runs
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         cfg_r.fec_en     <= 1'b0;
         cfg_r.short_mode <= 1'b0;
         cfg_r.cw_size    <= RST_CWSIZE;
         cfg_r.parity     <= RST_PARITY;
         cfg_r.guard      <= RST_GUARD;
         cfg_r.grant      <= RST_GRANT;
         cfg_r.len        <= RST_LEN;
         start_r          <= 1'b0;
      end
      else
      begin
         start_r <= 1'b0;
         if (wr_en && state_r == ST_IDLE)
         begin
            unique case (PADDR)
               OFS_CTRL:
               begin
                  // one mode chosen for the whole burst
                  cfg_r.fec_en     <= PWDATA[CTRL_FEC_EN];
                  cfg_r.short_mode <= PWDATA[CTRL_SHORT];
                  start_r          <= PWDATA[CTRL_START];
               end
               OFS_CWSIZE: cfg_r.cw_size <= PWDATA[7:0];
               OFS_PARITY: cfg_r.parity  <= PWDATA[7:0];
               OFS_GUARD:  cfg_r.guard   <= PWDATA[15:0];
               OFS_GRANT:  cfg_r.grant   <= PWDATA[15:0];
               OFS_LEN:    cfg_r.len     <= PWDATA[15:0];
               default:    ;
            endcase
         end
      end
   end

   // Room for information bytes once parity of the next codeword is set aside
   assign avail = (cap_r > {8'h00, cfg_r.parity}) ? (cap_r - {8'h00, cfg_r.parity}) : 16'h0000;
   assign out_free = !o_valid_r || O_READY;

   // Length of the next codeword, zero when none fits
   always_comb
   begin
      head_len = 16'h0000;
      // full codeword only while it fits with parity and guard
      if (avail >= {8'h00, cfg_r.cw_size} && cfg_r.cw_size >= MIN_INFO[7:0])
         head_len = {8'h00, cfg_r.cw_size};
      // shortened codeword only with 16 bytes of room
      else if (cfg_r.short_mode && avail >= MIN_INFO && cfg_r.cw_size >= MIN_INFO[7:0])
         head_len = avail;
   end

   // FIFO pop in data, bypass and drain phases
   always_comb
   begin
      f_pop = 1'b0;
      if (f_valid && data_left_r != 16'h0000)
      begin
         if (state_r == ST_DRAIN)
            f_pop = 1'b1;
         else if ((state_r == ST_BODY || state_r == ST_BYP) && out_free)
            f_pop = 1'b1;
      end
   end

   assign done_set  = (state_r == ST_HEAD && head_len == 16'h0000 && data_left_r == 16'h0000)
                   || (state_r == ST_BYP && f_pop && data_left_r == 16'h0001)
                   || (state_r == ST_DRAIN && f_pop && data_left_r == 16'h0001)
                   || (state_r == ST_BYP && data_left_r == 16'h0000);
   assign trunc_set = (state_r == ST_HEAD && head_len == 16'h0000 && data_left_r != 16'h0000);

   // Burst sequencer
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         state_r     <= ST_IDLE;
         data_left_r <= 16'h0000;
         cap_r       <= 16'h0000;
         cw_left_r   <= 8'h00;
         cw_len_r    <= 8'h00;
         first_r     <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
               if (start_r)
               begin
                  data_left_r <= cfg_r.len;
                  state_r     <= ST_PLAN;
               end
            ST_PLAN:
            begin
               // grant less guard planned before any byte
               cap_r   <= (cfg_r.grant > cfg_r.guard) ? (cfg_r.grant - cfg_r.guard) : 16'h0000;
               state_r <= cfg_r.fec_en ? ST_HEAD : ST_BYP;
            end
            ST_HEAD:
            begin
               // same fit test for every grant type
               if (head_len == 16'h0000)
                  state_r <= (data_left_r != 16'h0000) ? ST_DRAIN : ST_IDLE;
               else
               begin
                  // every codeword carries at least 16 bytes
                  cap_r     <= avail - head_len;
                  cw_left_r <= head_len[7:0];
                  cw_len_r  <= head_len[7:0];
                  first_r   <= 1'b1;
                  state_r   <= ST_BODY;
               end
            end
            ST_BODY:
               if (out_free && (data_left_r == 16'h0000 || f_valid))
               begin
                  if (data_left_r != 16'h0000)
                     data_left_r <= data_left_r - 16'h0001;
                  first_r   <= 1'b0;
                  cw_left_r <= cw_left_r - 8'h01;
                  if (cw_left_r == 8'h01)
                     state_r <= ST_HEAD;
               end
            ST_BYP:
               if (data_left_r == 16'h0000)
                  state_r <= ST_IDLE;
               else if (f_pop)
               begin
                  data_left_r <= data_left_r - 16'h0001;
                  if (data_left_r == 16'h0001)
                     state_r <= ST_IDLE;
               end
            ST_DRAIN:
               if (f_pop)
               begin
                  data_left_r <= data_left_r - 16'h0001;
                  if (data_left_r == 16'h0001)
                     state_r <= ST_IDLE;
               end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // Output stage, bytes marked with codeword bounds
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         o_valid_r <= 1'b0;
         beat_r    <= '0;
      end
      else
      begin
         if (O_READY)
            o_valid_r <= 1'b0;
         if (state_r == ST_BODY && out_free && (data_left_r == 16'h0000 || f_valid))
         begin
            // zero bytes once data run out
            // zero-fill up to the planned codeword end
            // zero codewords fill the remaining grant while one still fits
            o_valid_r     <= 1'b1;
            beat_r.data   <= (data_left_r != 16'h0000) ? f_data : 8'h00;
            beat_r.soc    <= first_r;
            beat_r.eoc    <= (cw_left_r == 8'h01);
            beat_r.cw_len <= cw_len_r;
         end
         else if (state_r == ST_BYP && f_pop)
         begin
            o_valid_r     <= 1'b1;
            beat_r.data   <= f_data;
            beat_r.soc    <= 1'b0;
            beat_r.eoc    <= 1'b0;
            beat_r.cw_len <= 8'h00;
         end
      end
   end
   assign O_VALID = o_valid_r;
   assign O_DATA  = beat_r.data;
   assign O_SOC   = beat_r.soc;
   assign O_EOC   = beat_r.eoc;
   assign O_CWLEN = beat_r.cw_len;

   // Sticky status, set wins over write-one clear
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         done_r       <= 1'b0;
         trunc_r      <= 1'b0;
         burst_done_r <= 1'b0;
      end
      else
      begin
         // Done only once the burst is over, after any drain
         burst_done_r <= done_set;
         if (done_set)
            done_r <= 1'b1;
         else if (wr_en && PADDR == OFS_STATUS && PWDATA[STAT_DONE])
            done_r <= 1'b0;
         // grant too small for the data is flagged
         if (trunc_set)
            trunc_r <= 1'b1;
         else if (wr_en && PADDR == OFS_STATUS && PWDATA[STAT_TRUNC])
            trunc_r <= 1'b0;
      end
   end
   assign O_BURST_DONE = burst_done_r;

   // Codewords issued in the current burst
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         cw_count_r <= 16'h0000;
      else if (state_r == ST_PLAN)
         cw_count_r <= 16'h0000;
      else if (state_r == ST_HEAD && head_len != 16'h0000)
         cw_count_r <= cw_count_r + 16'h0001;
   end

endmodule : ufcf_framer

// *** common/ufcf_pkg.sv ***
// Shared constants and carrier types for the upstream codeword framer
package ufcf_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CWSIZE = 8'h04;
   localparam logic [7:0] OFS_PARITY = 8'h08;
   localparam logic [7:0] OFS_GUARD  = 8'h0c;
   localparam logic [7:0] OFS_GRANT  = 8'h10;
   localparam logic [7:0] OFS_LEN    = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_COUNT  = 8'h1c;

   // Control field positions
   localparam int CTRL_FEC_EN = 0;
   localparam int CTRL_SHORT  = 1;
   localparam int CTRL_START  = 2;

   // Status field positions
   localparam int STAT_BUSY  = 0;
   localparam int STAT_DONE  = 1;
   localparam int STAT_TRUNC = 2;

   // Reset values
   localparam logic [7:0]  RST_CWSIZE = 8'h10;
   localparam logic [7:0]  RST_PARITY = 8'h00;
   localparam logic [15:0] RST_GUARD  = 16'h0000;
   localparam logic [15:0] RST_GRANT  = 16'h0000;
   localparam logic [15:0] RST_LEN    = 16'h0000;

   // Least information bytes in any codeword
   localparam logic [15:0] MIN_INFO = 16'h0010;

   // FIFO geometry
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;

   // Per-burst framing settings
   typedef struct packed {
      logic        fec_en;
      logic        short_mode;
      logic [7:0]  cw_size;
      logic [7:0]  parity;
      logic [15:0] guard;
      logic [15:0] grant;
      logic [15:0] len;
   } ufcf_cfg_t;

   // One output byte with its codeword marks
   typedef struct packed {
      logic [7:0] data;
      logic       soc;
      logic       eoc;
      logic [7:0] cw_len;
   } ufcf_beat_t;

   // Framer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_PLAN  = 6'b000010,
      ST_HEAD  = 6'b000100,
      ST_BODY  = 6'b001000,
      ST_BYP   = 6'b010000,
      ST_DRAIN = 6'b100000
   } ufcf_state_t;

endpackage : ufcf_pkg

// *** design/ufcf_fifo.sv ***
// Byte FIFO that buffers burst data ahead of the framer
`timescale 1ns/1ps
module ufcf_fifo
   import ufcf_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             full;
   logic             empty;

   // Honest full and empty from wrapped pointers
   assign empty     = (wr_ptr_r == rd_ptr_r);
   assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

   // Storage write
   always_ff @(posedge clk)
   begin
      if (in_valid && !full)
         mem_r[wr_ptr_r[AW-1:0]] <= in_data;
   end

   // Pointer update
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (in_valid && !full)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (out_ready && !empty)
            rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end

endmodule : ufcf_fifo

// *** verification/ufcf_framer_props.sv ***
// Port-level checks of the framer, bound to its top module
`timescale 1ns/1ps
module ufcf_framer_props
   import ufcf_pkg::*;
(
   input logic        MCLK,
   input logic        RST,
   input logic        PSEL,
   input logic        PENABLE,
   input logic        PWRITE,
   input logic [7:0]  PADDR,
   input logic [31:0] PWDATA,
   input logic        PREADY,
   input logic        PSLVERR,
   input logic        O_VALID,
   input logic        O_READY,
   input logic        O_SOC,
   input logic        O_EOC,
   input logic [7:0]  O_CWLEN,
   input logic        O_BURST_DONE
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   logic [7:0] pos_r;
   // Byte position inside the current codeword
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         pos_r <= 8'h00;
      else if (O_VALID && O_READY)
         pos_r <= (O_EOC || O_CWLEN == 8'h00) ? 8'h00 : pos_r + 8'h01;
   end
   // Setup phase and a burst start with framing on
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   sequence start_s;
      PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[2] && PWDATA[0];
   endsequence
   apb_ready_a:
      assert property (setup_s |=> PREADY) else $error("no ready after setup");
   err_ready_a:
      assert property (PSLVERR |-> PREADY && PSEL && PENABLE) else $error("error outside access");
   plan_gap_a:
      assert property (start_s |=> !O_VALID [*2]) else $error("byte before planning");
   min_info_a:
      assert property (O_VALID && O_SOC && O_CWLEN != 8'h00 |-> O_CWLEN >= 8'h10) else $error("codeword too short");
   cw_len_a:
      assert property (O_VALID && O_EOC && O_CWLEN != 8'h00 |-> pos_r + 8'h01 == O_CWLEN) else $error("bad length");
   cw_start_a:
      assert property (O_VALID && O_CWLEN != 8'h00 |-> O_SOC == (pos_r == 8'h00)) else $error("bad start mark");
   cw_steady_a:
      assert property (O_VALID && O_READY && !O_EOC && O_CWLEN != 8'h00 |=> !O_VALID || O_CWLEN == $past(O_CWLEN))
         else $error("length changed");
   hold_beat_a:
      assert property (O_VALID && !O_READY |=> O_VALID && $stable(O_CWLEN) && $stable(O_EOC)) else $error("beat dropped");
   bypass_flat_a:
      assert property (O_VALID && O_CWLEN == 8'h00 |-> !O_SOC && !O_EOC) else $error("marks in bypass");
   done_pulse_a:
      assert property (O_BURST_DONE |=> !O_BURST_DONE) else $error("done too long");
endmodule : ufcf_framer_props
bind ufcf_framer ufcf_framer_props ufcf_framer_props_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .O_VALID(O_VALID),
   .O_READY(O_READY), .O_SOC(O_SOC), .O_EOC(O_EOC), .O_CWLEN(O_CWLEN), .O_BURST_DONE(O_BURST_DONE));

// *** verification/ufcf_far_model.sv ***
// Far-side model: burst byte source and codeword sink
`timescale 1ns/1ps
module ufcf_far_model
   import ufcf_pkg::*;
(
   input  logic        clk,
   input  logic        rst,
   input  logic        go,
   input  logic        slow,
   input  logic [15:0] len,
   output logic        s_valid,
   input  logic        s_ready,
   output logic [7:0]  s_data,
   input  logic        o_valid,
   output logic        o_ready,
   input  ufcf_beat_t  beat,
   output logic [15:0] nb,
   output logic [15:0] ncw,
   output logic [15:0] errs
);
   logic [15:0] sent_r;
   logic        tog_r;
   logic [7:0]  expd;
   // source sends len bytes; grant sized by the bench
   assign s_valid = !go && sent_r < len;
   assign s_data  = s_valid ? sent_r[7:0] + 8'h01 : ~sent_r[7:0];
   assign o_ready = !slow || tog_r;
   assign expd    = (nb < len) ? nb[7:0] + 8'h01 : 8'h00;
   // Source count and sink stall toggle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst || go)
         sent_r <= 16'h0000;
      else if (s_valid && s_ready)
         sent_r <= sent_r + 16'h0001;
      tog_r <= rst ? 1'b0 : !tog_r;
   end
   // same layout check for every grant kind
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst || go)
      begin
         nb   <= 16'h0000;
         ncw  <= 16'h0000;
         errs <= 16'h0000;
      end
      else if (o_valid && o_ready)
      begin
         nb <= nb + 16'h0001;
         if (beat.eoc && beat.cw_len != 8'h00)
            ncw <= ncw + 16'h0001;
         if (beat.data !== expd || (beat.cw_len == 8'h00 && (beat.soc || beat.eoc)))
            errs <= errs + 16'h0001;
      end
   end
endmodule : ufcf_far_model

// *** verification/ufcf_framer_bench.sv ***
// Self-checking bench for the codeword framer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module ufcf_framer_bench
   import ufcf_pkg::*;
;
   logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, s_valid, s_ready, o_valid, o_ready, o_soc, o_eoc, o_done;
   logic [7:0]  s_data, o_data, o_cwlen;
   logic [15:0] flen = 16'h0000, nb, ncw, errs;
   ufcf_beat_t  beat;
   int          fails = 0, n_tests = 0, npulse = 0;
   assign beat = {o_data, o_soc, o_eoc, o_cwlen};
   // Clock
   always #2.5 mclk = ~mclk;
   ufcf_framer #(.DEPTH(16)) ufcf_framer_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .S_VALID(s_valid), .S_READY(s_ready), .S_DATA(s_data), .O_VALID(o_valid), .O_READY(o_ready),
      .O_DATA(o_data), .O_SOC(o_soc), .O_EOC(o_eoc), .O_CWLEN(o_cwlen), .O_BURST_DONE(o_done));
   ufcf_far_model ufcf_far_model_i (.clk(mclk), .rst(rst), .go(go), .slow(slow), .len(flen),
      .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data), .o_valid(o_valid), .o_ready(o_ready),
      .beat(beat), .nb(nb), .ncw(ncw), .errs(errs));
   // Burst end pulses since the last start
   always @(posedge mclk)
      if (go)
         npulse <= 0;
      else if (o_done === 1'b1)
         npulse <= npulse + 1;
   // Verdict and end of run
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // One bus transfer, setup then access until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t >= 20)
      begin
         fails++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One burst with its expected layout
   task automatic run(input int fec, sh, k, p, g, gr, ln, sl);
      int cap, av, l, ecw, enb, t;
      cap = gr - g;
      ecw = 0;
      enb = 0;
      while (fec)
      begin
         av = cap - p;
         if (av >= k && k >= 16)
            l = k;
         else if (sh && av >= 16 && k >= 16)
            l = av;
         else
            break;
         ecw++;
         enb += l;
         cap -= p + l;
      end
      if (!fec)
         enb = ln;
      apb(1'b1, OFS_CWSIZE, 32'(k));
      apb(1'b1, OFS_PARITY, 32'(p));
      apb(1'b1, OFS_GUARD, 32'(g));
      apb(1'b1, OFS_GRANT, 32'(gr));
      apb(1'b1, OFS_LEN, 32'(ln));
      slow <= sl[0];
      apb(1'b1, OFS_CTRL, 32'(4 + 2 * sh + fec));
      flen <= 16'(ln);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      if (fec)
         apb(1'b1, OFS_CWSIZE, 32'h33);
      t = 0;
      do
      begin
         apb(1'b0, OFS_STATUS, 32'h0);
         t++;
      end while (rd[STAT_DONE] !== 1'b1 && t < 500);
      if (t >= 500)
      begin
         fails++;
         end_sim();
      end
      `CHK("trunc", enb < ln, rd[STAT_TRUNC])
      apb(1'b0, OFS_COUNT, 32'h0);
      if (fec) `CHK("count", 32'(ecw), rd)
      `CHK("bytes", 16'(enb), nb)
      `CHK("codewords", 16'(ecw), ncw)
      `CHK("layout", 16'h0000, errs)
      `CHK("done pulses", 1, npulse)
      apb(1'b0, OFS_CWSIZE, 32'h0);
      `CHK("size kept", 32'(k), rd)
      apb(1'b1, OFS_STATUS, 32'h6);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", 32'h0, rd)
      $display("test done: fec %0d short %0d k %0d len %0d", fec, sh, k, ln);
   endtask : run
   // Main sequence
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, OFS_CWSIZE, 32'h0);
      `CHK("size reset", {24'h0, RST_CWSIZE}, rd)
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, OFS_PARITY + 8'(4 * i), 32'h0);
         `CHK("zero reset", 32'h0, rd)
      end
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      $display("test done: registers");
      run(1, 0, 16, 4, 0, 40, 16, 0);
      run(1, 0, 20, 4, 6, 80, 25, 1);
      run(1, 1, 32, 2, 4, 90, 40, 1);
      run(1, 1, 32, 2, 0, 85, 20, 0);
      run(1, 1, 20, 2, 0, 62, 50, 1);
      run(1, 0, 16, 0, 0, 16, 20, 0);
      run(0, 0, 16, 0, 0, 0, 10, 1);
      end_sim();
   end
   // Watchdog against a hang
   initial
   begin
      repeat (50000) @(posedge mclk);
      fails++;
      end_sim();
   end
endmodule : ufcf_framer_bench
